// >>> hdl/lmt_pkg.sv
// constants for the low power millisecond timebase
package lmt_pkg;
  // clock events per millisecond, first of each alternating pair
  localparam logic [7:0] BASE_32K = 8'h41; // 65 events, pair gives 65/66
  localparam logic [7:0] BASE_16K = 8'h20; // 32 events, pair gives 32/33
  // error correction intervals
  localparam logic [5:0] MS_PER_BLOCK = 6'h28; // 40 ms block
  localparam logic [9:0] MS_PER_SEC = 10'h3e8; // 1000 ms per second
  localparam int LAYERS = 15; // 1 s, 2 s ... 16384 s
  localparam int SEC_W = 14; // seconds counter wraps at 16384 s
  // widths
  localparam int TRIM_W = 4; // signed trim field
  localparam int MS_W = 30; // software millisecond counter
  localparam int SH_W = 24; // shadow coprocessor timer
  localparam int TS_W = 16; // time stamp width
  localparam int TS_N = 8; // time stamp count
  // reset values
  localparam logic [7:0] EVT_RST = 8'h00;
  localparam logic [29:0] MS_RST = 30'h0000_0000;
  localparam logic [23:0] SH_RST = 24'h00_0000;
  localparam logic [15:0] TS_RST = 16'h0000;
  // wakeup sequencer states
  typedef enum logic [1:0] {WK_IDLE, WK_POWER, WK_DELAY} lmt_wake_t;
endpackage

// >>> hdl/lmt_timebase.sv
// millisecond timebase with correction, timers, time stamps and wakeup sequencer
module lmt_timebase (
  input wire logic clk,
  input wire logic rst,
  input wire logic refClk, // reference clock, sampled on clk
  input wire logic refSel32, // 1: 32 kHz reference, 0: 16 kHz
  input wire logic [lmt_pkg::TRIM_W-1:0] trim, // signed period trim
  input wire logic corr40En, // add one event every 40 ms
  input wire logic [lmt_pkg::LAYERS-1:0] corrEn, // per layer enable
  input wire logic [lmt_pkg::LAYERS-1:0] corrDec, // per layer: 1 subtract
  input wire logic [7:0] timeoutPeriod, // ms, zero stops the timeout
  input wire logic msWrEn, // software write strobe
  input wire logic [lmt_pkg::MS_W-1:0] msWrData, // software write value
  input wire logic [lmt_pkg::TS_N-1:0] tsIrq, // time stamp interrupt sources
  input wire logic [lmt_pkg::TS_N-1:0] tsMask, // 1 masks the source
  input wire logic [7:0] kickDelay, // ms from power on to kick-off
  input wire logic pwrOn, // power manager: coprocessor domain on
  output logic msEvent, // one cycle per millisecond
  output logic timeoutEvt, // one cycle per timeout
  output logic [lmt_pkg::MS_W-1:0] msCount, // software counter
  output logic [lmt_pkg::SH_W-1:0] shadowTimer, // coprocessor timer
  output logic [lmt_pkg::TS_N*lmt_pkg::TS_W-1:0] stamps, // stamp i at [16i+15:16i]
  output logic wakeReq, // ask power manager to power coprocessor
  output logic kickoff // one cycle kick-off to coprocessor
);
  // event generator state
  // refPrev resets low, so a reference held high at release counts one event
  logic refPrev_r; // last sampled reference level
  logic [7:0] evCnt_r; // events inside current ms
  logic altBit_r; // 0: short period, 1: long period
  logic signed [5:0] adj_r; // correction applied to current period
  // correction interval counters
  logic [5:0] blkCnt_r; // ms inside 40 ms block
  logic [9:0] secMs_r; // ms inside second
  logic [lmt_pkg::SEC_W-1:0] secCnt_r; // whole seconds
  // timers and outputs
  logic [7:0] toCnt_r; // ms since last timeout
  logic msEvent_r;
  logic timeoutEvt_r;
  logic [lmt_pkg::MS_W-1:0] msCount_r;
  logic [lmt_pkg::SH_W-1:0] shadow_r;
  logic wakeReq_r;
  logic kickoff_r;
  logic [7:0] kickCnt_r; // ms waited after power on
  lmt_pkg::lmt_wake_t wake_r;

  // edge of reference in either direction is an event
  wire clkEvent = refClk ^ refPrev_r;

  // base period by reference rate, long period adds one
  wire [7:0] baseCnt = refSel32 ? lmt_pkg::BASE_32K : lmt_pkg::BASE_16K;
  // period = base + alternate + trim + pending correction in 10 bits, base and alternate zero-extended, trim and correction sign-extended
  wire signed [9:0] trimExt = 10'(signed'(trim));
  wire signed [9:0] periodW = $signed({2'b00, baseCnt}) + $signed({9'h000, altBit_r})
                              + trimExt + 10'(adj_r);
  // guard: a negative or zero period would stop time, hold at one
  wire [7:0] periodLast = (periodW < 10'sd2) ? 8'h00 : 8'(periodW - 10'sd1);
  wire msTick = clkEvent && (evCnt_r >= periodLast);

  // interval boundaries reached by the millisecond now closing
  wire blkEnd = (blkCnt_r == lmt_pkg::MS_PER_BLOCK - 6'h01);
  wire secEnd = (secMs_r == lmt_pkg::MS_PER_SEC - 10'h001);

  // per layer due flag and signed contribution
  logic [lmt_pkg::LAYERS-1:0] layerDue;
  genvar g;
  generate
    for (g = 0; g < lmt_pkg::LAYERS; g++) begin : gLayer
      if (g == 0) begin : gOne
        assign layerDue[g] = secEnd && corrEn[g];
      end else begin : gPow
        // 2^g seconds elapse when the low g second bits are all ones
        assign layerDue[g] = secEnd && corrEn[g] && (&secCnt_r[g-1:0]);
      end
    end
  endgenerate

  // sum every due adjustment into the next period
  // the sum rides on that one period only, adj falls back to zero after it
  logic signed [5:0] adjNxt;
  always_comb begin
    adjNxt = (blkEnd && corr40En) ? 6'sd1 : 6'sd0;
    for (int k = 0; k < lmt_pkg::LAYERS; k++) begin
      if (layerDue[k]) begin
        adjNxt = corrDec[k] ? adjNxt - 6'sd1 : adjNxt + 6'sd1;
      end
    end
  end

  // event counter and period sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      refPrev_r <= 1'b0;
      evCnt_r <= lmt_pkg::EVT_RST;
      altBit_r <= 1'b0;
      adj_r <= 6'sd0;
      msEvent_r <= 1'b0;
    end else begin
      refPrev_r <= refClk;
      msEvent_r <= msTick;
      if (msTick) begin
        evCnt_r <= lmt_pkg::EVT_RST;
        altBit_r <= ~altBit_r;
        adj_r <= adjNxt;
      end else if (clkEvent) begin
        evCnt_r <= evCnt_r + 8'h01;
      end
    end
  end

  // correction interval counters
  always_ff @(posedge clk) begin
    if (rst) begin
      blkCnt_r <= 6'h00;
      secMs_r <= 10'h000;
      secCnt_r <= '0;
    end else if (msTick) begin
      blkCnt_r <= blkEnd ? 6'h00 : blkCnt_r + 6'h01;
      secMs_r <= secEnd ? 10'h000 : secMs_r + 10'h001;
      if (secEnd) begin
        secCnt_r <= secCnt_r + 1'b1; // wraps at 16384 s
      end
    end
  end

  // timeout counter, period zero keeps it idle
  // lowering the period below the running count lets it run on to the 8-bit wrap
  wire toHit = msTick && (timeoutPeriod != 8'h00) && (toCnt_r + 8'h01 == timeoutPeriod);
  always_ff @(posedge clk) begin
    if (rst) begin
      toCnt_r <= 8'h00;
      timeoutEvt_r <= 1'b0;
    end else begin
      timeoutEvt_r <= toHit;
      if (toHit || timeoutPeriod == 8'h00) begin
        toCnt_r <= 8'h00;
      end else if (msTick) begin
        toCnt_r <= toCnt_r + 8'h01;
      end
    end
  end

  // software counter: a write in the tick cycle wins over the tick
  always_ff @(posedge clk) begin
    if (rst) begin
      msCount_r <= lmt_pkg::MS_RST;
      shadow_r <= lmt_pkg::SH_RST;
    end else begin
      if (msWrEn) begin
        msCount_r <= msWrData;
      end else if (msTick) begin
        msCount_r <= msCount_r + 30'h0000_0001;
      end
      if (msTick) begin
        shadow_r <= shadow_r + 24'h00_0001;
      end
    end
  end

  // time stamps latch the low shadow bits on unmasked sources
  generate
    for (g = 0; g < lmt_pkg::TS_N; g++) begin : gStamp
      logic [lmt_pkg::TS_W-1:0] stamp_r;
      // an unmasked source held high reloads its stamp on every cycle
      wire take = tsIrq[g] && !tsMask[g];
      always_ff @(posedge clk) begin
        if (rst) begin
          stamp_r <= lmt_pkg::TS_RST;
        end else if (take) begin
          stamp_r <= shadow_r[lmt_pkg::TS_W-1:0];
        end
      end
      assign stamps[g*lmt_pkg::TS_W +: lmt_pkg::TS_W] = stamp_r;
      // a masked source must leave its stamp untouched
      stamp_mask_a: assert property (@(posedge clk) disable iff (rst)
        tsMask[g] |=> $stable(stamp_r))
        else $error("masked source changed its time stamp");
    end
  endgenerate

  // wakeup sequencer; delay counted in ms, zero kicks on the first ms tick
  // timeouts arriving mid-sequence are dropped, not queued
  wire delayDone = msTick && (kickCnt_r >= kickDelay);
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_r <= lmt_pkg::WK_IDLE;
      wakeReq_r <= 1'b0;
      kickoff_r <= 1'b0;
      kickCnt_r <= 8'h00;
    end else begin
      kickoff_r <= 1'b0;
      case (wake_r)
        lmt_pkg::WK_IDLE: begin
          if (timeoutEvt_r) begin
            wakeReq_r <= 1'b1;
            wake_r <= lmt_pkg::WK_POWER;
          end
        end
        lmt_pkg::WK_POWER: begin
          // hold the request until the domain reports on
          kickCnt_r <= 8'h00;
          if (pwrOn) begin
            wake_r <= lmt_pkg::WK_DELAY;
          end
        end
        lmt_pkg::WK_DELAY: begin
          if (delayDone) begin
            kickoff_r <= 1'b1;
            wakeReq_r <= 1'b0;
            wake_r <= lmt_pkg::WK_IDLE;
          end else if (msTick) begin
            kickCnt_r <= kickCnt_r + 8'h01;
          end
        end
        default: begin
          wake_r <= lmt_pkg::WK_IDLE;
          wakeReq_r <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign msEvent = msEvent_r;
  assign timeoutEvt = timeoutEvt_r;
  assign msCount = msCount_r;
  assign shadowTimer = shadow_r;
  assign wakeReq = wakeReq_r;
  assign kickoff = kickoff_r;

  // checks on the design's own behaviour
  // attempts are dropped while reset is high; edge checks also skip the release cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // any reference edge advances or restarts the event count
  edge_event_a: assert property (!$past(rst) && $changed(refClk)
    |=> evCnt_r != $past(evCnt_r))
    else $error("reference edge did not count as event");
  // uncorrected 32 kHz periods alternate 65 and 66
  alt_period_a: assert property (msTick && refSel32 && trim == 4'h0 && adj_r == 6'sd0
    |-> evCnt_r == (altBit_r ? 8'h41 : 8'h40))
    else $error("32 kHz period not 65/66");
  alt_toggle_a: assert property (msTick |=> altBit_r != $past(altBit_r))
    else $error("period pattern did not alternate");
  // 40 ms correction reaches the next period
  blk_corr_a: assert property (msTick && blkEnd && corr40En && !secEnd
    |=> adj_r == 6'sd1)
    else $error("40 ms correction missing");
  // timeout fires at the programmed count and restarts
  timeout_hit_a: assert property (toHit |=> timeoutEvt_r && toCnt_r == 8'h00)
    else $error("timeout not raised or not restarted");
  // software write wins, tick otherwise increments
  ms_write_a: assert property (msWrEn |=> msCount_r == $past(msWrData))
    else $error("software write lost");
  ms_inc_a: assert property (msTick && !msWrEn |=> msCount_r == $past(msCount_r) + 30'h1)
    else $error("ms counter did not increment");
  shadow_inc_a: assert property (msTick |=> shadow_r == $past(shadow_r) + 24'h1)
    else $error("shadow timer did not increment");
  stamp_take_a: assert property (tsIrq[0] && !tsMask[0]
    |=> stamps[15:0] == $past(shadow_r[15:0]))
    else $error("time stamp not latched");
  wake_req_a: assert property (timeoutEvt_r && wake_r == lmt_pkg::WK_IDLE |=> wakeReq_r)
    else $error("no power request on expiry");
  kick_order_a: assert property (kickoff_r |-> $past(wake_r) == lmt_pkg::WK_DELAY)
    else $error("kick-off outside delay phase");
  // each millisecond pulse and kick-off lasts exactly one cycle
  ms_pulse_a: assert property (msEvent_r |=> !msEvent_r)
    else $error("millisecond pulse longer than one cycle");
  kick_pulse_a: assert property (kickoff_r |=> !kickoff_r)
    else $error("kick-off longer than one cycle");
  // a timeout is always one of the millisecond events
  timeout_pair_a: assert property (timeoutEvt_r |-> msEvent_r)
    else $error("timeout outside a millisecond event");
  // the request stands for the whole power-up wait
  wake_hold_a: assert property (wake_r == lmt_pkg::WK_POWER |-> wakeReq_r)
    else $error("power request dropped before power on");
  // away from interval ends the next period carries no correction
  blk_idle_a: assert property (msTick && !blkEnd && !secEnd |=> adj_r == 6'sd0)
    else $error("correction outside an interval end");
  // second end with secCnt_r[0] low: 40 ms add and 1 s subtract cancel, higher layers not due
  sec_sum_a: assert property (msTick && secEnd && corr40En && corrEn[0] && corrDec[0]
    && !secCnt_r[0] |=> adj_r == 6'sd0)
    else $error("one second correction not summed");
endmodule

// >>> bench/lmt_pwr_model.sv
// power manager model: powers the coprocessor domain some cycles after a request
module lmt_pwr_model #(
  parameter int DLY = 10 // pwrOn rises DLY+1 clk cycles after wakeReq
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wakeReq,
  output logic pwrOn
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt; // cycles since the request rose
  // slow on purpose, so the sequencer must really wait for the level
  always_ff @(posedge clk) begin
    if (rst || !wakeReq) begin
      cnt <= 0;
      pwrOn <= 1'b0;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
    end else begin
      pwrOn <= 1'b1;
    end
  end
endmodule

// >>> bench/tb_low_power_ms_timebase.sv
// self-checking bench for the millisecond timebase
module tb_low_power_ms_timebase;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, refClk, refSel32, corr40En, msWrEn, pwrOn;
  logic [14:0] corrEn, corrDec;
  logic msEvent, timeoutEvt, wakeReq, kickoff;
  logic [3:0] trim;
  logic [7:0] timeoutPeriod, kickDelay, tsIrq, tsMask;
  logic [29:0] msWrData, msCount;
  logic [23:0] shadowTimer;
  logic [127:0] stamps;
  int mismatches, n_compared;

  lmt_timebase uut (.clk(clk), .rst(rst), .refClk(refClk), .refSel32(refSel32), .trim(trim),
    .corr40En(corr40En), .corrEn(corrEn), .corrDec(corrDec), .timeoutPeriod(timeoutPeriod),
    .msWrEn(msWrEn), .msWrData(msWrData), .tsIrq(tsIrq), .tsMask(tsMask), .kickDelay(kickDelay),
    .pwrOn(pwrOn), .msEvent(msEvent), .timeoutEvt(timeoutEvt), .msCount(msCount),
    .shadowTimer(shadowTimer), .stamps(stamps), .wakeReq(wakeReq), .kickoff(kickoff));
  lmt_pwr_model pm (.clk(clk), .rst(rst), .wakeReq(wakeReq), .pwrOn(pwrOn));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // reference edge on every clk cycle, so one event is one cycle and a second fits the run
  always @(posedge clk) begin
    refClk <= ~refClk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // cycles up to and including the next ms pulse
  task automatic waitMs(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (msEvent !== 1'b1 && cyc < 5000);
  endtask
  task automatic doReset(input logic sel, input logic [3:0] tr);
    @(posedge clk);
    rst <= 1'b1;
    refSel32 <= sel;
    trim <= tr;
    {corr40En, msWrEn, corrEn, corrDec, timeoutPeriod, kickDelay, tsIrq, tsMask} <= '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask
  // the first period is skipped: its start depends on the reset phase
  task automatic testPeriod(input logic sel, input logic [3:0] tr, input int a, input int b);
    int c;
    doReset(sel, tr);
    waitMs(c);
    waitMs(c);
    check("second period", c, a);
    waitMs(c);
    check("third period", c, b);
  endtask
  // periods 2..41, the 40 ms block adds one event to period 41;
  // period 1001 sums that add with the 1 s subtract, higher layers not yet due
  task automatic testCorr40();
    int c, tot;
    doReset(1'b1, 4'h0);
    corr40En <= 1'b1;
    corrEn <= 15'h7fff;
    corrDec <= 15'h7fff;
    waitMs(c);
    tot = 0;
    repeat (40) begin
      waitMs(c);
      tot += c;
    end
    check("block length", tot, 2621);
    repeat (960) waitMs(c);
    check("period after one second", c, 65);
  endtask
  task automatic testTimeout();
    int n;
    doReset(1'b1, 4'h0);
    timeoutPeriod <= 8'h05;
    do @(negedge clk); while (timeoutEvt !== 1'b1);
    check("count at timeout", msCount, 5);
    n = 0;
    do begin
      @(negedge clk);
      n += (msEvent === 1'b1);
    end while (timeoutEvt !== 1'b1);
    check("ms per timeout", n, 5);
    @(posedge clk);
    msWrEn <= 1'b1;
    msWrData <= 30'h3fff_ffff;
    @(posedge clk);
    msWrEn <= 1'b0;
    @(negedge clk);
    check("written count", msCount, 32'h3fff_ffff);
    waitMs(n);
    check("count wraps", msCount, 0);
  endtask
  // lower four sources unmasked, upper four masked
  task automatic testStamp();
    int c;
    doReset(1'b1, 4'h0);
    repeat (3) waitMs(c);
    check("shadow timer", shadowTimer, 3);
    @(posedge clk);
    tsMask <= 8'hf0;
    tsIrq <= 8'hff;
    @(posedge clk);
    tsIrq <= 8'h00;
    @(negedge clk);
    for (int i = 0; i < 8; i++) check("stamp", stamps[16*i +: 16], (i < 4) ? 3 : 0);
  endtask
  task automatic testWake();
    int n;
    doReset(1'b1, 4'h0);
    timeoutPeriod <= 8'h02;
    kickDelay <= 8'h02;
    do @(negedge clk); while (timeoutEvt !== 1'b1);
    @(negedge clk);
    check("wake request", wakeReq, 1);
    do @(negedge clk); while (pwrOn !== 1'b1);
    n = 0;
    do begin
      @(negedge clk);
      n += (msEvent === 1'b1);
    end while (kickoff !== 1'b1);
    check("kick ticks", n, 3);
    check("request drop", wakeReq, 0);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run of about 68000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // main sequence
  initial begin
    {rst, refClk, refSel32, corr40En, msWrEn, trim, timeoutPeriod} = '0;
    {kickDelay, tsIrq, tsMask, msWrData, corrEn, corrDec} = '0;
    testPeriod(1'b1, 4'h0, 66, 65);
    testPeriod(1'b1, 4'he, 64, 63);
    testPeriod(1'b1, 4'h3, 69, 68);
    testPeriod(1'b0, 4'h0, 33, 32);
    testCorr40();
    testTimeout();
    testStamp();
    testWake();
    summarize();
  end
endmodule
